//--- bench/vectored_irq_ctrl_two_level_test.sv
// Purpose: Self-checking bench of the vectored interrupt controller.
// Assumes: Response channels are always ready, byte strobe always set.
// Notes: Peripheral flags and priorities are random from a fixed seed.
`timescale 1ns/1ns
module vectored_irq_ctrl_two_level_test;
  logic ref_clk = 1'h0, rst_b = 1'h0, awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, retiReq = 1'h0, missReq = 1'h0;
  logic irqLine0_b = 1'h1, irqLine1_b = 1'h1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic [1:0] bresp, rresp, ovf = 2'h0;
  logic [20:0] flagA = 21'h0, flagB = 21'h0, a, b, pri;
  virq_pkg::virq_cpu_t cpu;
  virq_pkg::virq_call_t call;
  int failures = 0, nChecks = 0, cyc, ord;
  always #5 ref_clk = ~ref_clk;
  virq_ctrl virq_ctrl_inst (.ref_clk(ref_clk), .rst_b(rst_b), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid),
    .s_axi_bready(1'h1), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(1'h1), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .extIrqLine0_b(irqLine0_b), .extIrqLine1_b(irqLine1_b), .timerOvfSet(ovf),
    .periphFlagA(flagA), .periphFlagB(flagB), .cpu(cpu), .call(call));
  virq_cpu_model virq_cpu_model_inst (.ref_clk(ref_clk), .rst_b(rst_b), .call(call),
    .retiReq(retiReq), .missReq(missReq), .cpu(cpu));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    nChecks++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d, input logic [1:0] er = 2'h0);
    awaddr <= ad;
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    chk("bresp", {30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] ad, input logic [1:0] er = 2'h0);
    araddr <= ad;
    arvalid <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rv = rdata;
    chk("rresp", {30'h0, rresp}, {30'h0, er});
  endtask
  task automatic waitCall();
    cyc = 0;
    while (call.callStrobe !== 1'h1 && cyc < 300) begin
      @(posedge ref_clk);
      cyc++;
    end
    chk("called", {31'h0, cyc < 300}, 32'h1);
  endtask
  task automatic ret();
    @(posedge ref_clk);
    retiReq <= 1'h1;
    @(posedge ref_clk);
    retiReq <= 1'h0;
  endtask
  // High level first, then lowest order; slot 19 and the internal orders never win.
  function automatic int pick(input logic [20:0] r, input logic [20:0] p);
    for (int l = 1; l >= 0; l--)
      for (int i = 4; i < 21; i++)
        if (r[i] && p[i] == l[0] && i != 19) return i;
    return 0;
  endfunction
  task automatic closeOut();
    $display("checks %0d failures %0d", nChecks, failures);
    if (failures == 0 && nChecks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    closeOut();
  end
  initial begin
    rv = $urandom(17);
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'h1;
    @(posedge ref_clk);
    rd(virq_pkg::OFS_PRIORITY0);
    chk("pri0", rv, 32'hC0);
    rd(virq_pkg::OFS_EXT_PRIORITY2);
    chk("pri2", rv, 32'h0);
    rd(8'h20, 2'h2);
    chk("unmapped", rv, 32'h0);
    irqLine1_b <= 1'h0;
    repeat (3) @(posedge ref_clk);
    rd(virq_pkg::OFS_TIMER_CTRL);
    chk("lvl on", {31'h0, rv[3]}, 32'h1);
    irqLine1_b <= 1'h1;
    repeat (3) @(posedge ref_clk);
    rd(virq_pkg::OFS_TIMER_CTRL);
    chk("lvl off", {31'h0, rv[3]}, 32'h0);
    wr(virq_pkg::OFS_TIMER_CTRL, 8'h01);
    wr(virq_pkg::OFS_ENABLE0, 8'h81);
    irqLine0_b <= 1'h0;
    waitCall();
    chk("latency", {31'h0, cyc >= 5}, 32'h1);
    chk("vec ext0", {16'h0, call.vector}, 32'h3);
    irqLine0_b <= 1'h1;
    ret();
    rd(virq_pkg::OFS_TIMER_CTRL);
    chk("edge clr", {31'h0, rv[1]}, 32'h0);
    wr(virq_pkg::OFS_ENABLE0, 8'h82);
    ovf <= 2'h1;
    @(posedge ref_clk);
    ovf <= 2'h0;
    repeat (2) @(posedge ref_clk);
    missReq <= 1'h1;
    repeat (3) @(posedge ref_clk);
    missReq <= 1'h0;
    waitCall();
    chk("vec tmr0", {16'h0, call.vector}, 32'hB);
    ret();
    rd(virq_pkg::OFS_TIMER_CTRL);
    chk("ovf clr", {31'h0, rv[5]}, 32'h0);
    wr(virq_pkg::OFS_ENABLE1, 8'hFF);
    wr(virq_pkg::OFS_EXT_ENABLE2, 8'h7F);
    for (int k = 0; k < 12; k++) begin
      a = 21'($urandom() & $urandom() & $urandom());
      b = 21'($urandom() & $urandom() & $urandom());
      pri = 21'($urandom());
      if (k == 0) a = 21'h180000;
      if (k == 0) b = 21'h0;
      if (((a | b) & 21'h17FFF0) == 21'h0) a = a | 21'h100000;
      wr(virq_pkg::OFS_ENABLE0, 8'h3F);
      flagA <= a;
      flagB <= b;
      wr(virq_pkg::OFS_PRIORITY0, {2'h0, pri[5:0]});
      wr(virq_pkg::OFS_PRIORITY1, pri[13:6]);
      wr(virq_pkg::OFS_EXT_PRIORITY2, {1'h0, pri[20:14]});
      chk("masked", {31'h0, call.callBusy}, 32'h0);
      wr(virq_pkg::OFS_ENABLE0, 8'hBF);
      waitCall();
      ord = pick(a | b, pri);
      chk("vector", {16'h0, call.vector}, 32'h3 + 32'(ord * 8));
      chk("level", {31'h0, call.level}, {31'h0, pri[ord]});
      ret();
      waitCall();
      chk("reentry", {16'h0, call.vector}, 32'h3 + 32'(ord * 8));
      flagA <= 21'h0;
      flagB <= 21'h0;
      ret();
      repeat (8) @(posedge ref_clk);
      chk("quiet", {31'h0, call.callBusy}, 32'h0);
    end
    closeOut();
  end
endmodule

//--- bench/virq_cpu_model.sv
// Purpose: Sequencer model that retires one instruction a cycle when idle.
// Assumes: Returns and fetch stalls are requested by the bench.
// Notes: Stalls only while a call runs, so a stuck request can hang it only once a call starts.
`timescale 1ns/1ns
module virq_cpu_model (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire virq_pkg::virq_call_t call,
  input wire logic retiReq,
  input wire logic missReq,
  output virq_pkg::virq_cpu_t cpu
);
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu <= '0;
    end else begin
      cpu.instrEnd <= !call.callBusy;
      cpu.isReti <= retiReq && !call.callBusy;
      cpu.cacheMiss <= missReq && call.callBusy;
    end
  end
endmodule

//--- bench/virq_ctrl_assertions.sv
// Purpose: Concurrent checks on the call side of the interrupt controller.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes: Bound to every controller instance at the foot of this file.
`timescale 1ns/1ns
module virq_ctrl_assertions #(
  parameter int CALL_CYCLES = virq_pkg::CALL_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire virq_pkg::virq_cpu_t cpu,
  input wire virq_pkg::virq_call_t call
);
  int busyCnt;
  // A counter keeps the length check valid for any call count.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      busyCnt <= 0;
    end else begin
      busyCnt <= call.callBusy ? busyCnt + 1 : 0;
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  a_strobe_single: assert property (call.callStrobe |=> !call.callStrobe)
    else $error("call strobe longer than one cycle");
  a_call_ends_strobe: assert property ($fell(call.callBusy) |-> call.callStrobe)
    else $error("call ended without strobe");
  a_call_length: assert property ($fell(call.callBusy) |-> busyCnt >= CALL_CYCLES)
    else $error("call shorter than the call count");
  a_take_boundary: assert property ($rose(call.callBusy) |-> $past(cpu.instrEnd)
    && !$past(cpu.isReti))
    else $error("call started off an instruction boundary");
  a_return_defers: assert property (cpu.instrEnd && cpu.isReti && !call.callBusy
    |=> !call.callBusy)
    else $error("call started right at a return");
  a_vector_legal: assert property (call.callStrobe |-> call.vector[2:0] == 3'h3
    && call.vector <= 16'h00A3 && call.vector != 16'h009B)
    else $error("illegal vector");
  a_vector_holds: assert property (!call.callStrobe |-> $stable(call.vector))
    else $error("vector changed without strobe");
  a_miss_stretch: assert property (call.callBusy && cpu.cacheMiss |=> call.callBusy)
    else $error("call ended during a fetch stall");
  a_call_bounded: assert property ($rose(call.callBusy) |-> ##[1:40] call.callStrobe)
    else $error("call never completed");
endmodule
bind virq_ctrl virq_ctrl_assertions #(.CALL_CYCLES(CALL_CYCLES)) virq_ctrl_assertions_inst (
  .ref_clk(ref_clk), .rst_b(rst_b), .cpu(cpu), .call(call));

//--- logic/virq_arbiter.sv
// Purpose: Fixed-order two-level pick among requesting interrupt sources.
// Assumes: Request vectors are already gated by enables and by the in-service level.
// Notes: Purely combinational; the caller registers the choice.
`timescale 1ns/1ns
module virq_arbiter #(
  parameter int NUM_SRC = virq_pkg::NUM_SRC,
  parameter int ORDER_W = virq_pkg::ORDER_W
) (
  input wire logic [NUM_SRC-1:0] reqHigh,
  input wire logic [NUM_SRC-1:0] reqLow,
  output logic pickValid,
  output logic pickLevel,
  output logic [ORDER_W-1:0] pickOrder
);

  if (NUM_SRC > (1 << ORDER_W)) begin : gBadWidth
    $error("virq_arbiter: ORDER_W too narrow for NUM_SRC");
  end

  function automatic logic [ORDER_W-1:0] lowestSet(input logic [NUM_SRC-1:0] vec);
    logic [ORDER_W-1:0] found;
    found = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (vec[i]) begin
        found = ORDER_W'(i);
      end
    end
    return found;
  endfunction

  wire logic anyHigh = |reqHigh;
  wire logic anyLow = |reqLow;
  wire logic [ORDER_W-1:0] highOrder = lowestSet(reqHigh);
  wire logic [ORDER_W-1:0] lowOrder = lowestSet(reqLow);

  assign pickValid = anyHigh | anyLow;
  assign pickLevel = anyHigh;
  assign pickOrder = anyHigh ? highOrder : lowOrder;

endmodule

//--- logic/virq_axil_slave.sv
// Purpose: AXI4-Lite slave front end that turns bus beats into single-cycle register requests.
// Assumes: The register file answers a request combinationally in the same cycle.
// Notes: Address and data of a write are taken in either order; one write and one read at a time.
`timescale 1ns/1ns
module virq_axil_slave #(
  parameter int ADDR_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic wrReq,
  output logic [ADDR_W-1:0] wrAddr,
  output logic [31:0] wrData,
  output logic [3:0] wrStrb,
  input wire logic wrOk,
  output logic rdReq,
  output logic [ADDR_W-1:0] rdAddr,
  input wire logic [31:0] rdData,
  input wire logic rdOk
);

  logic awHeld;
  logic wHeld;

  assign s_axi_awready = ~awHeld;
  assign s_axi_wready = ~wHeld;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wrReq = awHeld & wHeld & ~s_axi_bvalid;
  assign rdReq = s_axi_arvalid & s_axi_arready;
  assign rdAddr = s_axi_araddr;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      wrAddr <= '0;
      wrData <= 32'h00000000;
      wrStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= virq_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !awHeld) begin
        awHeld <= 1'b1;
        wrAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHeld) begin
        wHeld <= 1'b1;
        wrData <= s_axi_wdata;
        wrStrb <= s_axi_wstrb;
      end
      if (wrReq) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrOk ? virq_pkg::RESP_OKAY : virq_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        awHeld <= 1'b0;
        wHeld <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= virq_pkg::RESP_OKAY;
    end else if (rdReq) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdData;
      s_axi_rresp <= rdOk ? virq_pkg::RESP_OKAY : virq_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

//--- logic/virq_ctrl.sv
// Purpose: Vectored two-level interrupt controller between peripherals and the CPU sequencer.
// Assumes: Pins and peripheral flags are synchronous to ref_clk; the sequencer reports
//   instruction boundaries and returns, and performs the call while callBusy is high.
// Notes: Registers are eight bits wide in the low byte of each bus word.
// Notes on behaviour
// - Both external lines are active low; a per-line bit picks edge or level detection.
// - Pending flags of both external lines sit at fixed bits of timer control register.
// - In edge mode the external pending flag clears when the CPU vectors there.
// - In level mode the external pending flag mirrors the line and never latches.
// - Reset vector is zero; source n calls 0x0003 plus eight times n.
// - Only external 0/1 and timer 0/1 overflow flags clear on vectoring.
// - Comparator falling and rising events share one slot: flags A and B are ORed.
// - Orders 14 and up use the second extended enable and priority registers.
// - High requests may preempt low routines; high routines are never preempted.
// - Every priority bit resets to the low level.
// - Simultaneous requests: a high-level request wins over a low-level one.
// - Among equal levels the lowest order number wins.
// - Requests are sampled and priority decoded every clock cycle.
// - Fastest response is five clocks: one to detect, four to complete the call.
// - A request pending at a return waits exactly one further instruction.
// - Requests at or below the running level wait until its return and one instruction.
// - A cache miss during the call fetch lengthens the response.
// - The global enable must be set for any source enable to take effect.
// - Flags set whatever the enables; a flag left set re-enters after one instruction.
`timescale 1ns/1ns
module virq_ctrl #(
  parameter int NUM_SRC = virq_pkg::NUM_SRC,
  parameter int ADDR_W = 8,
  parameter int CALL_CYCLES = virq_pkg::CALL_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic extIrqLine0_b,
  input wire logic extIrqLine1_b,
  input wire logic [1:0] timerOvfSet,
  input wire logic [NUM_SRC-1:0] periphFlagA,
  input wire logic [NUM_SRC-1:0] periphFlagB,
  input wire virq_pkg::virq_cpu_t cpu,
  output virq_pkg::virq_call_t call
);

  if (NUM_SRC != virq_pkg::NUM_SRC) begin : gBadSrc
    $error("virq_ctrl: the source map is fixed at 21 slots");
  end
  if (CALL_CYCLES < 1 || CALL_CYCLES > 15) begin : gBadCall
    $error("virq_ctrl: CALL_CYCLES must lie in 1..15");
  end
  if (ADDR_W < 8) begin : gBadAddr
    $error("virq_ctrl: ADDR_W too narrow for the register map");
  end

  localparam int OW = virq_pkg::ORDER_W;

  // Register file.
  logic [7:0] timerCtrlReg;
  logic [7:0] enableReg0;
  logic [7:0] priorityReg0;
  logic [7:0] enableReg1;
  logic [7:0] priorityReg1;
  logic [7:0] extEnableReg2;
  logic [7:0] extPriorityReg2;

  // Bus request side.
  logic wrReq;
  logic [ADDR_W-1:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic rdReq;
  logic [ADDR_W-1:0] rdAddr;

  // Sequencing state.
  virq_pkg::virq_state_t state;
  logic [3:0] callCount;
  logic [OW-1:0] takenOrder;
  logic takenLevel;
  logic lowActive;
  logic highActive;
  logic prevLine0_b;
  logic prevLine1_b;

  function automatic logic [3:0] decodeReg(input logic [ADDR_W-1:0] addr);
    logic [3:0] sel;
    sel = 4'hF;
    if (addr[1:0] == 2'h0) begin
      unique case (addr[7:0])
        virq_pkg::OFS_TIMER_CTRL: sel = 4'h0;
        virq_pkg::OFS_ENABLE0: sel = 4'h1;
        virq_pkg::OFS_PRIORITY0: sel = 4'h2;
        virq_pkg::OFS_ENABLE1: sel = 4'h3;
        virq_pkg::OFS_PRIORITY1: sel = 4'h4;
        virq_pkg::OFS_EXT_ENABLE2: sel = 4'h5;
        virq_pkg::OFS_EXT_PRIORITY2: sel = 4'h6;
        virq_pkg::OFS_STATUS: sel = 4'h7;
        default: sel = 4'hF;
      endcase
    end
    if (ADDR_W > 8 && (addr >> 8) != '0) begin
      sel = 4'hF;
    end
    return sel;
  endfunction
  wire logic [3:0] wrSel = decodeReg(wrAddr);
  wire logic [3:0] rdSel = decodeReg(rdAddr);
  wire logic wrOk = (wrSel != 4'hF);
  wire logic rdOk = (rdSel != 4'hF);
  logic [31:0] rdData;

  virq_axil_slave #(
    .ADDR_W(ADDR_W)
  ) uBus (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .wrReq(wrReq),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .wrStrb(wrStrb),
    .wrOk(wrOk),
    .rdReq(rdReq),
    .rdAddr(rdAddr),
    .rdData(rdData),
    .rdOk(rdOk)
  );

  // Write decode: only the low byte lane carries register bits.
  wire logic wrLane = wrReq & wrStrb[0];
  wire logic [7:0] wrByte = wrData[7:0];
  wire logic wrTimerCtrl = wrLane & (wrSel == 4'h0);

  // Edge detection on the active-low lines.
  wire logic edge0Mode = timerCtrlReg[virq_pkg::TC_EXT0_EDGE];
  wire logic edge1Mode = timerCtrlReg[virq_pkg::TC_EXT1_EDGE];
  wire logic fall0 = prevLine0_b & ~extIrqLine0_b;
  wire logic fall1 = prevLine1_b & ~extIrqLine1_b;

  // Vectoring moment and which hardware-cleared flag it retires.
  wire logic vectorNow = (state == virq_pkg::ST_CALL) && (callCount == 4'h0) && !cpu.cacheMiss;
  wire logic clrExt0 = vectorNow && (takenOrder == OW'(virq_pkg::ORDER_EXT0));
  wire logic clrTmr0 = vectorNow && (takenOrder == OW'(virq_pkg::ORDER_TMR0));
  wire logic clrExt1 = vectorNow && (takenOrder == OW'(virq_pkg::ORDER_EXT1));
  wire logic clrTmr1 = vectorNow && (takenOrder == OW'(virq_pkg::ORDER_TMR1));

  // In level mode the pending bit is the line itself, so it is never stored.
  wire logic ext0Pending = edge0Mode ? timerCtrlReg[virq_pkg::TC_EXT0_PEND] : ~extIrqLine0_b;
  wire logic ext1Pending = edge1Mode ? timerCtrlReg[virq_pkg::TC_EXT1_PEND] : ~extIrqLine1_b;

  wire logic [7:0] timerCtrlView = {
    timerCtrlReg[7:4], ext1Pending, timerCtrlReg[2], ext0Pending, timerCtrlReg[0]
  };

  // Hardware set wins over a software or vectoring clear in the same cycle.
  function automatic logic nextFlag(input logic cur, input logic hwSet, input logic hwClr,
                                    input logic swWr, input logic swVal);
    logic val;
    val = cur;
    if (swWr) begin
      val = swVal;
    end
    if (hwClr) begin
      val = 1'b0;
    end
    if (hwSet) begin
      val = 1'b1;
    end
    return val;
  endfunction

  wire logic next_ext0Pend = nextFlag(timerCtrlReg[virq_pkg::TC_EXT0_PEND], fall0 & edge0Mode,
    clrExt0, wrTimerCtrl, wrByte[virq_pkg::TC_EXT0_PEND]);
  wire logic next_ext1Pend = nextFlag(timerCtrlReg[virq_pkg::TC_EXT1_PEND], fall1 & edge1Mode,
    clrExt1, wrTimerCtrl, wrByte[virq_pkg::TC_EXT1_PEND]);
  wire logic next_tmr0Ovf = nextFlag(timerCtrlReg[virq_pkg::TC_TMR0_OVF], timerOvfSet[0],
    clrTmr0, wrTimerCtrl, wrByte[virq_pkg::TC_TMR0_OVF]);
  wire logic next_tmr1Ovf = nextFlag(timerCtrlReg[virq_pkg::TC_TMR1_OVF], timerOvfSet[1],
    clrTmr1, wrTimerCtrl, wrByte[virq_pkg::TC_TMR1_OVF]);

  wire logic [7:0] next_timerCtrl = {
    next_tmr1Ovf, timerCtrlReg[6], next_tmr0Ovf, timerCtrlReg[4], next_ext1Pend,
    (wrTimerCtrl ? wrByte[2] : timerCtrlReg[2]), next_ext0Pend,
    (wrTimerCtrl ? wrByte[0] : timerCtrlReg[0])
  };

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      timerCtrlReg <= virq_pkg::REG_RESET;
      prevLine0_b <= 1'b1;
      prevLine1_b <= 1'b1;
    end else begin
      timerCtrlReg <= next_timerCtrl;
      prevLine0_b <= extIrqLine0_b;
      prevLine1_b <= extIrqLine1_b;
    end
  end

  // Enable and priority registers; all priorities reset to the low level.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      enableReg0 <= virq_pkg::REG_RESET;
      priorityReg0 <= virq_pkg::REG_RESET;
      enableReg1 <= virq_pkg::REG_RESET;
      priorityReg1 <= virq_pkg::REG_RESET;
      extEnableReg2 <= virq_pkg::REG_RESET;
      extPriorityReg2 <= virq_pkg::REG_RESET;
    end else if (wrLane) begin
      unique case (wrSel)
        4'h1: enableReg0 <= wrByte;
        4'h2: priorityReg0 <= wrByte & virq_pkg::PRI0_STORE_MASK;
        4'h3: enableReg1 <= wrByte;
        4'h4: priorityReg1 <= wrByte;
        4'h5: extEnableReg2 <= wrByte & virq_pkg::EXT2_STORE_MASK;
        4'h6: extPriorityReg2 <= wrByte & virq_pkg::EXT2_STORE_MASK;
        default: ;
      endcase
    end
  end

  // Per-source request, enable and priority maps in order 0..20.
  wire logic [NUM_SRC-1:0] srcEnable = {
    extEnableReg2[6:0], enableReg1, enableReg0[5:0]
  };
  wire logic [NUM_SRC-1:0] srcPriority = {
    extPriorityReg2[6:0], priorityReg1, priorityReg0[5:0]
  };
  wire logic [NUM_SRC-1:0] localFlags = {
    {(NUM_SRC - 4){1'b0}}, timerCtrlReg[virq_pkg::TC_TMR1_OVF], ext1Pending,
    timerCtrlReg[virq_pkg::TC_TMR0_OVF], ext0Pending
  };
  wire logic [NUM_SRC-1:0] periphMask = virq_pkg::SRC_VALID_MASK & ~NUM_SRC'(21'h00000F);
  wire logic [NUM_SRC-1:0] srcPending = localFlags
    | ((periphFlagA | periphFlagB) & periphMask);
  wire logic globalOn = enableReg0[virq_pkg::EN0_GLOBAL];
  wire logic [NUM_SRC-1:0] srcReq = srcPending & srcEnable & virq_pkg::SRC_VALID_MASK
    & {NUM_SRC{globalOn}};

  // A running high routine blocks all; a running low routine admits only high.
  wire logic [NUM_SRC-1:0] reqHigh = srcReq & srcPriority & {NUM_SRC{~highActive}};
  wire logic [NUM_SRC-1:0] reqLow = srcReq & ~srcPriority
    & {NUM_SRC{~highActive & ~lowActive}};

  logic pickValid;
  logic pickLevel;
  logic [OW-1:0] pickOrder;

  virq_arbiter #(
    .NUM_SRC(NUM_SRC),
    .ORDER_W(OW)
  ) uArb (
    .reqHigh(reqHigh),
    .reqLow(reqLow),
    .pickValid(pickValid),
    .pickLevel(pickLevel),
    .pickOrder(pickOrder)
  );

  // A boundary that ends a return never takes a request, so one more instruction runs first.
  wire logic takeNow = (state == virq_pkg::ST_IDLE) && pickValid
    && cpu.instrEnd && !cpu.isReti;
  wire logic retiNow = cpu.instrEnd && cpu.isReti;
  wire logic [15:0] takenVector = virq_pkg::VEC_BASE
    + (16'(takenOrder) << virq_pkg::VEC_STEP_SHIFT);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= virq_pkg::ST_IDLE;
      callCount <= 4'h0;
      takenOrder <= '0;
      takenLevel <= 1'b0;
    end else begin
      unique case (state)
        virq_pkg::ST_IDLE: begin
          if (takeNow) begin
            state <= virq_pkg::ST_CALL;
            callCount <= 4'(CALL_CYCLES - 1);
            takenOrder <= pickOrder;
            takenLevel <= pickLevel;
          end
        end
        virq_pkg::ST_CALL: begin
          if (cpu.cacheMiss) begin
            callCount <= callCount;
          end else if (callCount == 4'h0) begin
            state <= virq_pkg::ST_IDLE;
          end else begin
            callCount <= callCount - 4'h1;
          end
        end
      endcase
    end
  end

  // In-service levels: set at vectoring, the highest one retired at each return.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lowActive <= 1'b0;
      highActive <= 1'b0;
    end else begin
      if (vectorNow && takenLevel) begin
        highActive <= 1'b1;
      end else if (retiNow && highActive) begin
        highActive <= 1'b0;
      end
      if (vectorNow && !takenLevel) begin
        lowActive <= 1'b1;
      end else if (retiNow && !highActive) begin
        lowActive <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      call.callBusy <= 1'b0;
      call.callStrobe <= 1'b0;
      call.vector <= virq_pkg::VEC_RESET;
      call.level <= 1'b0;
    end else begin
      call.callBusy <= takeNow | (call.callBusy & ~vectorNow);
      call.callStrobe <= vectorNow;
      if (vectorNow) begin
        call.vector <= takenVector;
        call.level <= takenLevel;
      end
    end
  end

  // Read side; reserved bits read as fixed constants, except unused enable 0 bit 6, which reads back as written.
  wire logic [7:0] statusView = {highActive, lowActive, call.callBusy, takenOrder};
  logic [7:0] rdByte;
  always_comb begin
    rdByte = 8'h00;
    unique case (rdSel)
      4'h0: rdByte = timerCtrlView;
      4'h1: rdByte = enableReg0;
      4'h2: rdByte = priorityReg0 | virq_pkg::PRI0_READ_ONES;
      4'h3: rdByte = enableReg1;
      4'h4: rdByte = priorityReg1;
      4'h5: rdByte = extEnableReg2;
      4'h6: rdByte = extPriorityReg2;
      4'h7: rdByte = statusView;
      default: rdByte = 8'h00;
    endcase
  end
  assign rdData = {24'h000000, rdByte};

endmodule

//--- logic/virq_pkg.sv
// Purpose: Shared constants and carrier types of the vectored interrupt controller.
// Assumes: One 100 MHz clock, eight-bit control registers on a 32-bit register bus.
// Notes: Register byte offsets are multiples of four; each register is one word.
package virq_pkg;

  localparam int NUM_SRC = 21;
  localparam int ORDER_W = 5;
  localparam int RESERVED_SLOT = 19;

  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam logic [15:0] VEC_LAST = 16'h00A3;
  localparam int VEC_STEP_SHIFT = 3;

  localparam int CLK_PERIOD_NS = 10;
  localparam int DETECT_CYCLES = 1;
  localparam int CALL_CYCLES = 4;
  localparam int MIN_RESPONSE_CYCLES = DETECT_CYCLES + CALL_CYCLES;

  localparam logic [7:0] OFS_TIMER_CTRL = 8'h00;
  localparam logic [7:0] OFS_ENABLE0 = 8'h04;
  localparam logic [7:0] OFS_PRIORITY0 = 8'h08;
  localparam logic [7:0] OFS_ENABLE1 = 8'h0C;
  localparam logic [7:0] OFS_PRIORITY1 = 8'h10;
  localparam logic [7:0] OFS_EXT_ENABLE2 = 8'h14;
  localparam logic [7:0] OFS_EXT_PRIORITY2 = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;

  localparam int TC_EXT0_EDGE = 0;
  localparam int TC_EXT0_PEND = 1;
  localparam int TC_EXT1_EDGE = 2;
  localparam int TC_EXT1_PEND = 3;
  localparam int TC_TMR0_OVF = 5;
  localparam int TC_TMR1_OVF = 7;
  localparam int EN0_GLOBAL = 7;

  localparam int ORDER_EXT0 = 0;
  localparam int ORDER_TMR0 = 1;
  localparam int ORDER_EXT1 = 2;
  localparam int ORDER_TMR1 = 3;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] TC_STORE_MASK = 8'h05;
  localparam logic [7:0] PRI0_READ_ONES = 8'hC0;
  localparam logic [7:0] PRI0_STORE_MASK = 8'h3F;
  localparam logic [7:0] EXT2_STORE_MASK = 8'h5F;
  localparam logic [20:0] SRC_VALID_MASK = 21'h17FFFF;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic instrEnd;
    logic isReti;
    logic cacheMiss;
  } virq_cpu_t;

  typedef struct packed {
    logic callBusy;
    logic callStrobe;
    logic [15:0] vector;
    logic level;
  } virq_call_t;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_CALL
  } virq_state_t;

endpackage
